/* File: msc_consts.vh */
// Purpose: Shared constants of the monitor sequencer control block
// Assumes: 100 MHz block clock
// Notes: Offsets are byte addresses of the 7-bit register space
`ifndef MSC_CONSTS_VH
`define MSC_CONSTS_VH
// Register offsets
`define MSC_OFS_STATUS 7'h00
`define MSC_OFS_VDD_RES 7'h06
`define MSC_OFS_AIN_RES 7'h08
`define MSC_OFS_CFG1 7'h18
`define MSC_OFS_CFG2 7'h19
`define MSC_OFS_CFG3 7'h1A
`define MSC_OFS_MASK 7'h1D
`define MSC_OFS_LIM_HI 7'h30
`define MSC_OFS_LIM_LO 7'h38
// Reset values
`define MSC_RST_CFG1 8'h00
`define MSC_RST_CFG2 8'h00
`define MSC_RST_CFG3 8'h00
`define MSC_RST_MASK 8'h00
`define MSC_RST_LIM_HI 8'hFF
`define MSC_RST_LIM_LO 8'h00
// Field positions
`define MSC_C1_MON_EN 0
`define MSC_C1_PIN7_AIN 1
`define MSC_C1_PIN8_AIN 2
`define MSC_C1_ALARM_HIGH 6
`define MSC_C2_SINGLE 4
`define MSC_C2_AVG_OFF 5
`define MSC_C3_FAST 0
`define MSC_C3_REF_VDD 4
// Channel codes
`define MSC_CH_VDD 4'h0
`define MSC_CH_INT 4'h1
`define MSC_CH_EXT 4'h2
`define MSC_CH_AIN1 4'h3
`define MSC_CH_AIN3 4'h5
`define MSC_CH_AIN8 4'hA
// Timing
`define MSC_CAL_TIME_US 5000
`define MSC_CLK_MHZ 100
`define MSC_AVG_LAST 4'hF
`define MSC_SPI_SEL_EDGES 2'h3
`endif

/* File: msc_avg.v */
// Purpose: Sixteen-sample averager for converter results
// Assumes: Samples arrive as one-cycle strobes on the block clock
// Notes: o_more asks for another sample, o_done carries the final mean
`timescale 1ns/1ps
`include "msc_consts.vh"
module msc_avg (
  // Clock and reset
  input wire i_mclk,
  input wire i_rstn,
  // Control
  input wire i_clr,
  input wire i_avg_en,
  // Sample in
  input wire i_valid,
  input wire [9:0] i_data,
  // Result out
  output reg o_more,
  output reg o_done,
  output reg [9:0] o_result
);
  reg [13:0] acc_q;
  reg [3:0] cnt_q;
  wire [13:0] sum = acc_q + {4'h0, i_data};

  always @(posedge i_mclk)
  begin
    if (!i_rstn || i_clr)
    begin
      acc_q <= 14'h0000;
      cnt_q <= 4'h0;
      o_more <= 1'b0;
      o_done <= 1'b0;
      o_result <= 10'h000;
    end
    else
    begin
      o_more <= 1'b0;
      o_done <= 1'b0;
      if (i_valid)
      begin
        if (!i_avg_en)
        begin
          o_result <= i_data;
          o_done <= 1'b1;
          // Drop any partial sum so re-enabled averaging starts clean
          acc_q <= 14'h0000;
          cnt_q <= 4'h0;
        end
        else if (cnt_q == `MSC_AVG_LAST)
        begin
          o_result <= sum[13:4];
          o_done <= 1'b1;
          acc_q <= 14'h0000;
          cnt_q <= 4'h0;
        end
        else
        begin
          acc_q <= sum;
          cnt_q <= cnt_q + 4'h1;
          o_more <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: msc_ctrl.v */
// Purpose: Measurement sequencer, limit check and serial register access
// Assumes: Converter core on the block clock; serial pins asynchronous
// Notes: Serial framing is a minimal SPI byte pair; I2C engine is external
`timescale 1ns/1ps
`include "msc_consts.vh"
module msc_ctrl #(
  parameter CAL_CYCLES = `MSC_CAL_TIME_US * `MSC_CLK_MHZ
) (
  // Clock and reset
  input wire i_mclk,
  input wire i_rstn,
  // SPI pins
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_din,
  output reg o_dout,
  output reg o_dout_oe,
  // External I2C engine register port
  input wire i_i2c_busy,
  input wire i_i2c_wr,
  input wire i_i2c_rd,
  input wire [6:0] i_i2c_addr,
  input wire [7:0] i_i2c_wdata,
  output reg [7:0] o_i2c_rdata,
  // Converter core
  output reg o_adc_start,
  output reg o_adc_reset,
  output reg [3:0] o_adc_chan,
  output reg o_adc_fast,
  output reg o_ref_vdd,
  output reg o_pins_diode,
  output reg o_diode_filter_en,
  input wire i_adc_done,
  input wire [9:0] i_adc_data,
  // Status
  output reg o_spi_mode,
  output reg o_idle,
  output reg o_alarm
);
  localparam S_CAL = 2'h0;
  localparam S_IDLE = 2'h1;
  localparam S_CONV = 2'h2;
  localparam S_HOLD = 2'h3;

  reg [1:0] state_q;
  reg [22:0] cal_cnt_q;
  reg [7:0] cfg1_q;
  reg [7:0] cfg2_q;
  reg [7:0] cfg3_q;
  reg [7:0] mask_q;
  reg [7:0] status_q;
  reg [7:0] vdd_res_q;
  reg [7:0] lim_hi_q [0:7];
  reg [7:0] lim_lo_q [0:7];
  reg [7:0] ain_res_q [0:7];
  reg [2:0] sclk_s;
  reg [2:0] cs_s;
  reg [1:0] din_s;
  reg [1:0] sel_cnt_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] sh_q;
  reg [6:0] addr_q;
  reg rd_q;
  reg phase_q;
  reg load_q;
  reg [7:0] tx_q;
  reg [7:0] rdata;
  reg [3:0] next_ch;
  reg [6:0] ra;
  integer i;

  wire sclk_rise = (sclk_s[2:1] == 2'b01);
  wire sclk_fall = (sclk_s[2:1] == 2'b10);
  wire cs_fall = (cs_s[2:1] == 2'b10);
  wire cs_act = ~cs_s[1];
  wire mon_en = cfg1_q[`MSC_C1_MON_EN];
  wire single = cfg2_q[`MSC_C2_SINGLE];
  wire pins_ain = cfg1_q[`MSC_C1_PIN7_AIN] | cfg1_q[`MSC_C1_PIN8_AIN];
  wire busy = o_spi_mode ? cs_act : i_i2c_busy;
  wire [7:0] hdr = {sh_q[6:0], din_s[1]};
  wire spi_byte = o_spi_mode & cs_act & sclk_rise & (bit_cnt_q == 4'h7);
  wire spi_wr = spi_byte & phase_q & ~rd_q;
  wire wr_en = o_spi_mode ? spi_wr : i_i2c_wr;
  wire [6:0] wr_addr = o_spi_mode ? addr_q : i_i2c_addr;
  wire [7:0] wr_data = o_spi_mode ? hdr : i_i2c_wdata;
  wire rd_en = o_spi_mode ? load_q : i_i2c_rd;
  wire avg_more;
  wire avg_done;
  wire [9:0] avg_res;
  wire [7:0] res8 = avg_res[9:2];
  wire is_ain = (o_adc_chan >= `MSC_CH_AIN1);
  wire [3:0] ain_idx4 = o_adc_chan - `MSC_CH_AIN1;
  wire [2:0] ain_idx = ain_idx4[2:0];
  wire out_lim = (res8 > lim_hi_q[ain_idx]) | (res8 <= lim_lo_q[ain_idx]);
  wire [7:0] flag_set = (avg_done && is_ain && out_lim) ?
    ((8'h01 << ain_idx) & ~mask_q) : 8'h00;
  wire flag_clr = rd_en && (ra == `MSC_OFS_STATUS);
  wire conv_go = (state_q == S_CONV) && !busy && mon_en;

  msc_avg u_avg (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_clr(state_q != S_CONV),
    .i_avg_en(~cfg2_q[`MSC_C2_AVG_OFF]),
    .i_valid(i_adc_done && conv_go),
    .i_data(i_adc_data),
    .o_more(avg_more),
    .o_done(avg_done),
    .o_result(avg_res)
  );

  // Read address and read mux
  always @*
  begin
    ra = o_spi_mode ? addr_q : i_i2c_addr;
    rdata = 8'h00;
    if (ra == `MSC_OFS_STATUS)
      rdata = status_q;
    else if (ra == `MSC_OFS_VDD_RES)
      rdata = vdd_res_q;
    else if (ra == `MSC_OFS_CFG1)
      rdata = cfg1_q;
    else if (ra == `MSC_OFS_CFG2)
      rdata = cfg2_q;
    else if (ra == `MSC_OFS_CFG3)
      rdata = cfg3_q;
    else if (ra == `MSC_OFS_MASK)
      rdata = mask_q;
    else if (ra[6:3] == `MSC_OFS_AIN_RES >> 3)
      rdata = ain_res_q[ra[2:0]];
    else if (ra[6:3] == `MSC_OFS_LIM_HI >> 3)
      rdata = lim_hi_q[ra[2:0]];
    else if (ra[6:3] == `MSC_OFS_LIM_LO >> 3)
      rdata = lim_lo_q[ra[2:0]];
  end

  // Next channel of the scan
  always @*
  begin
    next_ch = `MSC_CH_VDD;
    if (single)
      next_ch = cfg2_q[3:0];
    else
    begin
      case (o_adc_chan)
        `MSC_CH_VDD: next_ch = `MSC_CH_INT;
        `MSC_CH_INT: next_ch = pins_ain ? `MSC_CH_AIN1 : `MSC_CH_EXT;
        `MSC_CH_EXT: next_ch = `MSC_CH_AIN3;
        `MSC_CH_AIN8: next_ch = `MSC_CH_VDD;
        default: next_ch = o_adc_chan + 4'h1;
      endcase
    end
  end

  // Pin synchronisers
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      din_s <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], i_sclk};
      cs_s <= {cs_s[1:0], i_cs_n};
      din_s <= {din_s[0], i_din};
    end
  end

  // Serial mode lock and SPI byte engine
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_spi_mode <= 1'b0;
      sel_cnt_q <= 2'h0;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= 7'h00;
      rd_q <= 1'b0;
      phase_q <= 1'b0;
      load_q <= 1'b0;
      tx_q <= 8'h00;
      o_dout <= 1'b1;
      o_dout_oe <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      if (!o_spi_mode && cs_fall)
      begin
        sel_cnt_q <= sel_cnt_q + 2'h1;
        if (sel_cnt_q == `MSC_SPI_SEL_EDGES - 2'h1)
          o_spi_mode <= 1'b1;
      end
      if (!cs_act)
      begin
        bit_cnt_q <= 4'h0;
        phase_q <= 1'b0;
        o_dout_oe <= 1'b0;
        o_dout <= 1'b1;
      end
      else if (o_spi_mode)
      begin
        if (sclk_rise)
        begin
          sh_q <= hdr;
          bit_cnt_q <= (bit_cnt_q == 4'h7) ? 4'h0 : bit_cnt_q + 4'h1;
          if (spi_byte)
          begin
            phase_q <= ~phase_q;
            if (!phase_q)
            begin
              rd_q <= hdr[7];
              addr_q <= hdr[6:0];
              load_q <= hdr[7];
            end
          end
        end
        if (load_q)
          tx_q <= rdata;
        if (sclk_fall && phase_q && rd_q)
        begin
          o_dout <= tx_q[7];
          o_dout_oe <= ~tx_q[7];
          tx_q <= {tx_q[6:0], 1'b0};
        end
        else if (sclk_fall)
        begin
          o_dout <= 1'b1;
          o_dout_oe <= 1'b0;
        end
      end
    end
  end

  // Register file, status flags and I2C read data
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      cfg1_q <= `MSC_RST_CFG1;
      cfg2_q <= `MSC_RST_CFG2;
      cfg3_q <= `MSC_RST_CFG3;
      mask_q <= `MSC_RST_MASK;
      status_q <= 8'h00;
      vdd_res_q <= 8'h00;
      o_i2c_rdata <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
        lim_hi_q[i] <= `MSC_RST_LIM_HI;
        lim_lo_q[i] <= `MSC_RST_LIM_LO;
        ain_res_q[i] <= 8'h00;
      end
    end
    else
    begin
      if (wr_en)
      begin
        if (wr_addr == `MSC_OFS_CFG1)
          cfg1_q <= wr_data;
        if (wr_addr == `MSC_OFS_CFG2)
          cfg2_q <= wr_data;
        if (wr_addr == `MSC_OFS_CFG3)
          cfg3_q <= wr_data;
        if (wr_addr == `MSC_OFS_MASK)
          mask_q <= wr_data;
        if (wr_addr[6:3] == `MSC_OFS_LIM_HI >> 3)
          lim_hi_q[wr_addr[2:0]] <= wr_data;
        if (wr_addr[6:3] == `MSC_OFS_LIM_LO >> 3)
          lim_lo_q[wr_addr[2:0]] <= wr_data;
      end
      if (i_i2c_rd && !o_spi_mode)
        o_i2c_rdata <= rdata;
      status_q <= (status_q & ~{8{flag_clr}}) | flag_set;
      if (avg_done && o_adc_chan == `MSC_CH_VDD)
        vdd_res_q <= res8;
      if (avg_done && is_ain)
        ain_res_q[ain_idx] <= res8;
    end
  end

  // Sequencer
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state_q <= S_CAL;
      cal_cnt_q <= 23'h000000;
      o_adc_start <= 1'b0;
      o_adc_reset <= 1'b1;
      o_adc_chan <= `MSC_CH_VDD;
      o_idle <= 1'b0;
    end
    else
    begin
      o_adc_start <= 1'b0;
      case (state_q)
        S_CAL:
        begin
          cal_cnt_q <= cal_cnt_q + 23'h000001;
          if (cal_cnt_q == CAL_CYCLES[22:0] - 23'h000001)
          begin
            state_q <= S_IDLE;
            o_idle <= 1'b1;
          end
        end
        S_IDLE:
        begin
          o_adc_reset <= 1'b1;
          o_idle <= 1'b1;
          if (mon_en && !busy)
          begin
            state_q <= S_CONV;
            o_adc_chan <= single ? cfg2_q[3:0] : `MSC_CH_VDD;
            o_adc_reset <= 1'b0;
            o_adc_start <= 1'b1;
            o_idle <= 1'b0;
          end
        end
        S_CONV:
        begin
          if (!mon_en)
            state_q <= S_IDLE;
          else if (busy)
          begin
            state_q <= S_HOLD;
            o_adc_reset <= 1'b1;
          end
          else if (avg_done)
          begin
            o_adc_chan <= next_ch;
            o_adc_start <= 1'b1;
          end
          else if (avg_more)
            o_adc_start <= 1'b1;
        end
        S_HOLD:
        begin
          if (!mon_en)
            state_q <= S_IDLE;
          else if (!busy)
          begin
            state_q <= S_CONV;
            o_adc_reset <= 1'b0;
            o_adc_start <= 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Converter configuration pins and alarm output
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      o_adc_fast <= 1'b0;
      o_ref_vdd <= 1'b0;
      o_pins_diode <= 1'b1;
      o_diode_filter_en <= 1'b1;
      o_alarm <= 1'b1;
    end
    else
    begin
      o_adc_fast <= cfg3_q[`MSC_C3_FAST];
      o_ref_vdd <= cfg3_q[`MSC_C3_REF_VDD] & is_ain;
      o_pins_diode <= ~pins_ain;
      o_diode_filter_en <= ~cfg3_q[`MSC_C3_FAST] & ~pins_ain;
      o_alarm <= (|status_q) ~^ cfg1_q[`MSC_C1_ALARM_HIGH];
    end
  end
endmodule

/* File: msc_ctrl_chk.sv */
// Purpose: Port assertions of the sequencer control block
// Assumes: Bound to every msc_ctrl instance
// Notes: Channel code 0 is the supply, 3 to 10 the analog inputs
`timescale 1ns/1ps
module msc_ctrl_chk #(
  parameter CAL_CYCLES = 500000
) (
  input wire i_mclk,
  input wire i_rstn,
  input wire i_i2c_busy,
  input wire i_i2c_wr,
  input wire [6:0] i_i2c_addr,
  input wire [7:0] i_i2c_wdata,
  input wire o_adc_start,
  input wire o_adc_reset,
  input wire [3:0] o_adc_chan,
  input wire o_adc_fast,
  input wire o_ref_vdd,
  input wire o_diode_filter_en,
  input wire o_spi_mode,
  input wire o_idle
);
  logic [31:0] cyc_q;
  logic [3:0] last_chan_q;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);
  // Cycles since release and channel of the last start
  always @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      cyc_q <= 32'h0;
      last_chan_q <= 4'h0;
    end
    else
    begin
      if (cyc_q < CAL_CYCLES)
        cyc_q <= cyc_q + 32'h1;
      if (o_adc_start)
        last_chan_q <= o_adc_chan;
    end
  end
  chk_cal_first: assert property (cyc_q + 2 < CAL_CYCLES |-> !o_idle)
    else $error("idle during calibration");
  chk_idle_quiet: assert property (o_idle && $past(o_idle) |-> !o_adc_start)
    else $error("start while idle");
  chk_enable_start: assert property (
    i_i2c_wr && !i_i2c_busy && !o_spi_mode && o_idle && i_i2c_addr == 7'h18 &&
    i_i2c_wdata[0] |-> ##[1:2] (o_adc_start && o_adc_chan == 4'h0))
    else $error("enable did not start supply");
  chk_wrap_supply: assert property (
    o_adc_start && last_chan_q == 4'hA && o_adc_chan != 4'hA |-> o_adc_chan == 4'h0)
    else $error("scan did not wrap to supply");
  chk_fast_nofilt: assert property (o_adc_fast && $past(o_adc_fast) |-> !o_diode_filter_en)
    else $error("filter on at fast clock");
  chk_busy_abort: assert property (i_i2c_busy && !o_spi_mode |-> ##[1:2] o_adc_reset)
    else $error("traffic did not reset converter");
  chk_reset_nostart: assert property (o_adc_reset |-> !o_adc_start)
    else $error("start while converter held");
  chk_ref_ain: assert property (o_ref_vdd && $stable(o_adc_chan) |-> o_adc_chan >= 4'h3)
    else $error("supply reference off analog input");
  chk_spi_locked: assert property (!$fell(o_spi_mode))
    else $error("serial mode unlocked");
  cov_wrap: cover property (o_adc_start && o_adc_chan == 4'hA);
  cov_lock: cover property ($rose(o_spi_mode));
  cov_fast: cover property (o_adc_fast && o_ref_vdd);
endmodule
bind msc_ctrl msc_ctrl_chk #(.CAL_CYCLES(CAL_CYCLES)) u_msc_ctrl_chk (.i_mclk(i_mclk),
  .i_rstn(i_rstn), .i_i2c_busy(i_i2c_busy), .i_i2c_wr(i_i2c_wr), .i_i2c_addr(i_i2c_addr),
  .i_i2c_wdata(i_i2c_wdata), .o_adc_start(o_adc_start), .o_adc_reset(o_adc_reset),
  .o_adc_chan(o_adc_chan), .o_adc_fast(o_adc_fast), .o_ref_vdd(o_ref_vdd),
  .o_diode_filter_en(o_diode_filter_en), .o_spi_mode(o_spi_mode), .o_idle(o_idle));

/* File: msc_conv_model.sv */
// Purpose: Converter core stand-in answering each start pulse
// Assumes: Start and reset come on the block clock
// Notes: Samples alternate base+8 and base-8, so a mean of 16 is the base
`timescale 1ns/1ps
module msc_conv_model #(
  parameter DLY = 5
) (
  input wire i_mclk,
  input wire i_start,
  input wire i_reset,
  input wire [3:0] i_chan,
  output reg o_done = 1'b0,
  output reg [9:0] o_data = 10'h000
);
  integer cnt_q = 0;
  reg odd_q = 1'b0;
  always @(posedge i_mclk)
  begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_reset)
      cnt_q <= 0;
    else if (i_start)
      cnt_q <= DLY;
    else if (cnt_q > 1)
      cnt_q <= cnt_q - 1;
    else if (cnt_q == 1)
    begin
      cnt_q <= 0;
      o_done <= 1'b1;
      o_data <= {i_chan, 6'h20} + (odd_q ? 10'h3F8 : 10'h008);
      odd_q <= ~odd_q;
    end
  end
endmodule

/* File: msc_ctrl_test.sv */
// Purpose: Self-checking bench of the sequencer control block
// Assumes: Calibration cut to 20 cycles
// Notes: Register rows first, then scan, mode and serial cases
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
`define WAITC(c, n) begin for (w = 0; w < n && !(c); w++) @(posedge i_mclk); \
if (!(c)) begin n_mismatch++; close_out; end end
module msc_ctrl_test;
  reg i_mclk = 1'b0, i_rstn = 1'b0, i_sclk = 1'b0, i_cs_n = 1'b1, i_din = 1'b0;
  reg i_i2c_busy = 1'b0, i_i2c_wr = 1'b0, i_i2c_rd = 1'b0;
  reg [6:0] i_i2c_addr = 7'h00;
  reg [7:0] i_i2c_wdata = 8'h00, rd_q = 8'h00;
  reg [3:0] prev = 4'hF;
  reg [3:0] seq [0:15];
  wire o_dout, o_dout_oe, o_adc_start, o_adc_reset, o_adc_fast, o_ref_vdd, o_pins_diode;
  wire o_diode_filter_en, o_spi_mode, o_idle, o_alarm, i_adc_done;
  wire [7:0] o_i2c_rdata;
  wire [3:0] o_adc_chan;
  wire [9:0] i_adc_data;
  wire sdo = o_dout_oe ? 1'b0 : 1'b1;
  wire [5:0] st = {o_adc_reset, o_idle, o_spi_mode, o_diode_filter_en, o_alarm, o_adc_fast};
  integer n_mismatch = 0, total_checks = 0, run = 0, last_run = 0, n_seq = 0, i, w, k;
  // Address, reset value, write data, read back
  localparam logic [31:0] ROWS [10] = '{32'h18000000, 32'h19000000, 32'h1A000000,
    32'h1D00D0D0, 32'h32FF5858, 32'h3B006868, 32'h35FF8787, 32'h34FF7777,
    32'h05003300, 32'h0000FF00};
  localparam logic [3:0] SEQ [11] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
    4'h9, 4'hA, 4'h0};
  msc_ctrl #(.CAL_CYCLES(20)) u_msc_ctrl (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .i_i2c_busy(i_i2c_busy), .i_i2c_wr(i_i2c_wr), .i_i2c_rd(i_i2c_rd),
    .i_i2c_addr(i_i2c_addr), .i_i2c_wdata(i_i2c_wdata), .o_i2c_rdata(o_i2c_rdata),
    .o_adc_start(o_adc_start), .o_adc_reset(o_adc_reset), .o_adc_chan(o_adc_chan),
    .o_adc_fast(o_adc_fast), .o_ref_vdd(o_ref_vdd), .o_pins_diode(o_pins_diode),
    .o_diode_filter_en(o_diode_filter_en), .i_adc_done(i_adc_done),
    .i_adc_data(i_adc_data), .o_spi_mode(o_spi_mode), .o_idle(o_idle), .o_alarm(o_alarm));
  msc_conv_model u_msc_conv_model (.i_mclk(i_mclk), .i_start(o_adc_start),
    .i_reset(o_adc_reset), .i_chan(o_adc_chan), .o_done(i_adc_done), .o_data(i_adc_data));
  always #5 i_mclk = ~i_mclk;
  // Channel order and samples per channel
  always @(posedge i_mclk)
  begin
    if (i_adc_done)
      run <= run + 1;
    if (o_adc_start && o_adc_chan !== prev)
    begin
      seq[n_seq % 16] <= o_adc_chan;
      n_seq <= n_seq + 1;
      last_run <= run;
      run <= 0;
      prev <= o_adc_chan;
    end
  end
  task close_out;
  begin
    if (n_mismatch == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task wr(input [6:0] a, input [7:0] d);
  begin
    i_i2c_addr <= a;
    i_i2c_wdata <= d;
    i_i2c_wr <= 1'b1;
    @(posedge i_mclk);
    i_i2c_wr <= 1'b0;
    @(posedge i_mclk);
  end
  endtask
  task rd(input [6:0] a);
  begin
    i_i2c_addr <= a;
    i_i2c_rd <= 1'b1;
    @(posedge i_mclk);
    i_i2c_rd <= 1'b0;
    @(posedge i_mclk);
    rd_q = o_i2c_rdata;
  end
  endtask
  task cs_fall;
  begin
    i_cs_n <= 1'b0;
    #100;
    i_cs_n <= 1'b1;
    #100;
    @(posedge i_mclk);
  end
  endtask
  // One frame at 125 ns link period, read bits taken before each rise
  task spi(input [15:0] f);
  begin
    i_cs_n <= 1'b0;
    for (i = 15; i >= 0; i--)
    begin
      i_din <= f[i];
      #62.5;
      rd_q[i % 8] = sdo;
      i_sclk <= 1'b1;
      #62.5;
      i_sclk <= 1'b0;
    end
    #62.5;
    i_cs_n <= 1'b1;
    i_din <= ~i_din;
    #250;
    @(posedge i_mclk);
  end
  endtask
  initial
  begin
    repeat (4) @(posedge i_mclk);
    `CHK("reset outputs", 6'h26, st)
    i_rstn <= 1'b1;
    `WAITC(o_idle, 100)
    for (k = 0; k < 10; k++)
    begin
      rd(ROWS[k][30:24]);
      `CHK("reset value", ROWS[k][23:16], rd_q)
      wr(ROWS[k][30:24], ROWS[k][15:8]);
      rd(ROWS[k][30:24]);
      `CHK("read back", ROWS[k][7:0], rd_q)
    end
    wr(7'h18, 8'h03);
    `WAITC(n_seq >= 11, 6000)
    for (i = 0; i < 11; i++)
      `CHK("scan order", SEQ[i], seq[i])
    `CHK("samples per result", 16, last_run)
    `CHK("pins and alarm", 2'b00, {o_pins_diode, o_alarm})
    wr(7'h18, 8'h43);
    @(posedge i_mclk);
    `CHK("alarm high", 1'b1, o_alarm)
    rd(7'h00);
    `CHK("status", 8'h28, rd_q)
    rd(7'h08);
    `CHK("input one result", 8'h38, rd_q)
    wr(7'h19, 8'h20);
    k = n_seq;
    `WAITC(n_seq >= k + 3, 600)
    `CHK("samples per result", 1, last_run)
    wr(7'h19, 8'h30);
    repeat (20) @(posedge i_mclk);
    `WAITC(prev === 4'h0, 300)
    k = n_seq;
    repeat (100) @(posedge i_mclk);
    `CHK("single channel", k, n_seq)
    i_i2c_busy <= 1'b1;
    repeat (3) @(posedge i_mclk);
    `CHK("abort", 1'b1, o_adc_reset)
    i_i2c_busy <= 1'b0;
    `WAITC(o_adc_start, 20)
    wr(7'h19, 8'h00);
    wr(7'h18, 8'h01);
    @(posedge i_mclk);
    `CHK("diode slow", 3'b110, {o_pins_diode, o_diode_filter_en, o_adc_fast})
    wr(7'h1A, 8'h11);
    @(posedge i_mclk);
    `CHK("diode fast", 2'b10, {o_adc_fast, o_diode_filter_en})
    `WAITC(o_adc_chan >= 4'h3, 1500)
    @(posedge i_mclk);
    `CHK("input reference", 1'b1, o_ref_vdd)
    wr(7'h18, 8'h00);
    repeat (2) @(posedge i_mclk);
    `CHK("stopped", 2'b11, {o_idle, o_adc_reset})
    cs_fall;
    cs_fall;
    `CHK("two wire mode", 1'b0, o_spi_mode)
    cs_fall;
    `CHK("locked", 1'b1, o_spi_mode)
    wr(7'h18, 8'h01);
    repeat (3) @(posedge i_mclk);
    `CHK("two wire refused", 1'b1, o_idle)
    spi(16'h1801);
    `WAITC(!o_idle, 50)
    spi(16'h9800);
    `CHK("serial read", 8'h01, rd_q)
    i_rstn <= 1'b0;
    repeat (4) @(posedge i_mclk);
    `CHK("power cycle", 2'b01, {o_spi_mode, o_adc_reset})
    close_out;
  end
endmodule
